/* File: hdl/sram_host_ctrl.sv */
/*
  Host controller for an asynchronous 32K x 8 static memory.
  Assumes a single 25 MHz clock; request inputs synchronous to it; the
  testbench resolves the data wire from data_oe.
*/
`timescale 1ns/1ps
`include "sram_port_consts.svh"

module sram_host_ctrl
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // User request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  // Memory pins
  output logic [ADDR_W-1:0] mem_addr,
  output logic chip_sel_b,
  output logic write_strobe_b,
  output logic out_drive_b,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in
);

  function automatic logic [`CNT_W-1:0] cyc(input int n);
    cyc = n[`CNT_W-1:0];
  endfunction : cyc

  // True once a wait count has run out
  function automatic logic cnt_done(input logic [`CNT_W-1:0] c);
    cnt_done = (c == `CNT_ZERO);
  endfunction : cnt_done

  ctl_state_e state_reg, state_next;
  mem_ctl_s pins_reg, pins_next;
  logic [`CNT_W-1:0] cnt_reg, cnt_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic ready_reg, ready_next;
  logic rdv_reg, rdv_next;
  logic [DATA_W-1:0] rdat_reg, rdat_next;
  // Counter load request and read capture strobe from the sequencer
  logic cnt_load;
  logic [`CNT_W-1:0] cnt_load_val;
  logic rd_capture;

  // Sequencer, memory controls and data drive
  always_comb begin
    state_next = state_reg;
    pins_next = pins_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    ready_next = ready_reg;
    cnt_load = 1'b0;
    cnt_load_val = `CNT_ZERO;
    rd_capture = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // Deselected: standby, all controls high, pins floating
        pins_next.chip_sel_b = 1'b1;
        pins_next.write_strobe_b = 1'b1;
        pins_next.out_drive_b = 1'b1;
        oe_next = 1'b0;
        if (req_valid && ready_reg) begin
          ready_next = 1'b0;
          // Address set a cycle before select falls
          pins_next.addr = req_addr[`ADDR_W-1:0];
          if (req_write) begin
            dout_next = req_wdata;
            state_next = ST_WR_FLOAT;
          end else begin
            state_next = ST_RD_SETUP;
          end
        end
      end
      ST_RD_SETUP: begin
        pins_next.chip_sel_b = 1'b0;
        pins_next.out_drive_b = 1'b0;
        pins_next.write_strobe_b = 1'b1;
        cnt_load = 1'b1;
        cnt_load_val = cyc(`READ_CYC);
        state_next = ST_RD_WAIT;
      end
      ST_RD_WAIT: begin
        if (cnt_done(cnt_reg)) begin
          rd_capture = 1'b1;
          // Further reads stay selected; new address is a fresh access
          if (req_valid && !req_write) begin
            pins_next.addr = req_addr[`ADDR_W-1:0];
            cnt_load = 1'b1;
            cnt_load_val = cyc(`READ_CYC);
          end else begin
            pins_next.chip_sel_b = 1'b1;
            pins_next.out_drive_b = 1'b1;
            ready_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      ST_WR_FLOAT: begin
        // Drive stays high so the memory never drives during a write
        pins_next.out_drive_b = 1'b1;
        pins_next.chip_sel_b = 1'b0;
        pins_next.write_strobe_b = 1'b0;
        cnt_load = 1'b1;
        cnt_load_val = cyc(`FLOAT_CYC);
        state_next = ST_WR_DATA;
      end
      ST_WR_DATA: begin
        if (cnt_done(cnt_reg)) begin
          // Data after the float delay, then setup plus pulse width
          oe_next = 1'b1;
          cnt_load = 1'b1;
          cnt_load_val = cyc(`SETUP_CYC + `PULSE_CYC);
          state_next = ST_WR_END;
        end
      end
      ST_WR_END: begin
        if (cnt_done(cnt_reg)) begin
          // Strobe ends the write; select and data hold a cycle longer
          pins_next.write_strobe_b = 1'b1;
          state_next = ST_IDLE;
          ready_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  // Wait counter: a load wins over the count down
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_load) begin
      cnt_next = cnt_load_val;
    end else if (!cnt_done(cnt_reg)) begin
      cnt_next = cnt_reg - `CNT_ONE;
    end
  end

  // Read return: one-cycle valid, byte held until the next read
  always_comb begin
    rdv_next = rd_capture;
    rdat_next = rdat_reg;
    if (rd_capture) begin
      rdat_next = data_in;
    end
  end

  // The idle state drops select and data one cycle after the strobe rose
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      pins_reg <= '{addr: '0, chip_sel_b: 1'b1, write_strobe_b: 1'b1, out_drive_b: 1'b1};
      dout_reg <= '0;
      oe_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= `CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdv_reg <= 1'b0;
      rdat_reg <= '0;
    end else begin
      rdv_reg <= rdv_next;
      rdat_reg <= rdat_next;
    end
  end

  assign mem_addr = pins_reg.addr;
  assign chip_sel_b = pins_reg.chip_sel_b;
  assign write_strobe_b = pins_reg.write_strobe_b;
  assign out_drive_b = pins_reg.out_drive_b;
  assign data_out = dout_reg;
  assign data_oe = oe_reg;
  assign req_ready = ready_reg;
  assign rd_valid = rdv_reg;
  assign rd_data = rdat_reg;

endmodule : sram_host_ctrl

/* File: hdl/sram_port_consts.svh */
/*
  Timing and layout constants for the static memory port controller.
  Assumes a 25 MHz system clock; times in ns, counts derived by rounding.
*/
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

`define CLK_PERIOD_NS 40
`define ADDR_W 15
`define DATA_W 8
// Strobe-to-float delay and write data setup time, worst grade
`define STROBE_TO_FLOAT_DELAY_NS 7
`define WRITE_DATA_SETUP_TIME_NS 8
`define READ_CYCLE_NS 15
`define WRITE_PULSE_NS 10
// Least times round up, never below one cycle
`define CEIL_CYC(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define FLOAT_CYC `CEIL_CYC(`STROBE_TO_FLOAT_DELAY_NS)
`define SETUP_CYC `CEIL_CYC(`WRITE_DATA_SETUP_TIME_NS)
`define PULSE_CYC `CEIL_CYC(`WRITE_PULSE_NS)
`define READ_CYC `CEIL_CYC(`READ_CYCLE_NS)
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1

`endif

/* File: hdl/sram_port_pkg.sv */
/*
  Types for the static memory port controller.
  Assumes the constants header is included first.
*/
`include "sram_port_consts.svh"

package sram_port_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_SETUP,
    ST_RD_WAIT,
    ST_WR_FLOAT,
    ST_WR_DATA,
    ST_WR_END
  } ctl_state_e;

  // Pin group seen by the memory, all active-low controls
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic chip_sel_b;
    logic write_strobe_b;
    logic out_drive_b;
  } mem_ctl_s;
endpackage : sram_port_pkg

/* File: verification/sram_mem_model.sv */
/* Behavioural 32K x 8 static memory.
   Assumes the bench resolves the data wire from both drivers. */
`timescale 1ns/1ps
module sram_mem_model (
  // Memory pins
  input wire logic [14:0] addr,
  input wire logic chip_sel_b,
  input wire logic write_strobe_b,
  input wire logic out_drive_b,
  input wire logic [7:0] dbus,
  output logic [7:0] q
);
  logic [7:0] mem [0:32767];
  logic wr = 1'b0;
  wire drive = !chip_sel_b && write_strobe_b && !out_drive_b;
  // Byte lands on whichever control rises first
  always @(chip_sel_b, write_strobe_b) begin
    if (!chip_sel_b && !write_strobe_b) wr = 1'b1;
    else if (wr) begin
      mem[addr] = dbus;
      wr = 1'b0;
    end
  end
  // Released wire shows the inverted byte, never the held byte
  always @* q = drive ? mem[addr] : ~mem[addr];
endmodule : sram_mem_model

/* File: verification/sram_host_ctrl_asserts.sv */
/* Pin-level checker for the memory host controller.
   Assumes bind into sram_host_ctrl, single clock domain. */
`timescale 1ns/1ps
module sram_host_ctrl_asserts #(parameter int ADDR_W = 15, parameter int DATA_W = 8) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // User side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rd_valid,
  // Memory pins
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic chip_sel_b,
  input wire logic write_strobe_b,
  input wire logic out_drive_b,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire take = req_valid && req_ready;
  no_contend_a: assert property (data_oe |-> out_drive_b) else $error("data contention");
  rd_strobe_a: assert property (!out_drive_b |-> write_strobe_b && !chip_sel_b) else $error("read ctl");
  wr_drive_a: assert property (!write_strobe_b |-> out_drive_b && !chip_sel_b) else $error("write ctl");
  data_hold_a: assert property ($rose(write_strobe_b) |-> data_oe && $stable(data_out)) else $error("hold");
  cs_end_a: assert property ($rose(chip_sel_b) |-> $past(write_strobe_b)) else $error("cs end");
  addr_set_a: assert property ($fell(chip_sel_b) |-> $stable(mem_addr)) else $error("addr late");
  rd_lat_a: assert property (take && !req_write |-> ##[4:5] rd_valid) else $error("read latency");
  wr_lat_a: assert property (take && req_write |-> ##[1:3] !(chip_sel_b || write_strobe_b) ##[3:6] req_ready)
    else $error("write seq");
  cover property (rd_valid);
  cover property ($rose(write_strobe_b));
  cover property (take && !req_write);
  cover property (!chip_sel_b && !out_drive_b && $changed(mem_addr));
endmodule : sram_host_ctrl_asserts
bind sram_host_ctrl sram_host_ctrl_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_i (.*);

/* File: verification/sram_host_ctrl_tb.sv */
/* Self-checking bench: random writes, read-back, retention sweep.
   Assumes the memory model and the bound checker. */
`timescale 1ns/1ps
module sram_host_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [14:0] req_addr = 15'h0;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rd_valid, data_oe, chip_sel_b, write_strobe_b, out_drive_b;
  logic [7:0] rd_data, data_out, mdq;
  logic [14:0] mem_addr;
  logic [7:0] ref_mem [int];
  logic [7:0] q [$];
  int n_errors = 0;
  int n_checks = 0;
  int tick = 0;
  wire [7:0] dbus = data_oe ? data_out : mdq;
  sram_host_ctrl DUT (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_addr(mem_addr), .chip_sel_b(chip_sel_b), .write_strobe_b(write_strobe_b), .out_drive_b(out_drive_b),
    .data_out(data_out), .data_oe(data_oe), .data_in(dbus));
  sram_mem_model mem (.addr(mem_addr), .chip_sel_b(chip_sel_b), .write_strobe_b(write_strobe_b),
    .out_drive_b(out_drive_b), .dbus(dbus), .q(mdq));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Waits for ready first so a request never lands in the refused window
  task automatic op(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n = 0;
    if (!w) q.push_back(ref_mem[a]);
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n++ < 20) @(negedge clk_sys);
    if (req_ready !== 1'b1) n_errors++;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask : op
  // Second read held up while the first completes, so select stays low
  task automatic rd2(input logic [14:0] a, input logic [14:0] b);
    int n = 0;
    q.push_back(ref_mem[a]);
    q.push_back(ref_mem[b]);
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n++ < 20) @(negedge clk_sys);
    if (req_ready !== 1'b1) n_errors++;
    req_valid = 1'b1;
    req_write = 1'b0;
    req_addr = a;
    @(negedge clk_sys);
    req_addr = b;
    repeat (3) @(negedge clk_sys);
    req_valid = 1'b0;
  endtask : rd2
  initial forever #20 clk_sys = ~clk_sys;
  // Outputs looked at mid-cycle, away from the edge that launches them
  always @(negedge clk_sys) begin
    tick++;
    if (tick == 3000) begin
      n_errors++;
      tally_and_finish();
    end
    if (rst_b && rd_valid === 1'b1) chk("rd_data", q.pop_front(), rd_data);
  end
  initial begin
    logic [14:0] a;
    logic [7:0] d;
    void'($urandom(16));
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1'b1;
    for (int i = 0; i < 12; i++) begin
      a = (i < 2) ? {15{i[0]}} : 15'($urandom);
      d = 8'($urandom);
      ref_mem[a] = d;
      op(1'b1, a, d);
      op(1'b0, a, 8'h00);
    end
    foreach (ref_mem[k]) op(1'b0, 15'(k), 8'h00);
    rd2(15'h0000, 15'h7FFF);
    repeat (8) @(negedge clk_sys);
    chk("chip_sel_b", 8'h01, {7'h00, chip_sel_b});
    chk("pending_reads", 8'h00, 8'(q.size()));
    tally_and_finish();
  end
endmodule : sram_host_ctrl_tb
